// [hdl/dac_sched_pkg.sv]
// Package: register map, control fields, reset values and word formatting for the DAC scheduler
package dac_sched_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned NUM_REGS = 7;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONV0_DATA_HIGH = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONV0_DATA_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONV0_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CONV1_DATA_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CONV1_DATA_LOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CONV1_CONTROL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CODE_STATUS = 8'h20;

  // One-hot select positions
  localparam int unsigned SEL_HIGH = 0;
  localparam int unsigned SEL_LOW = 1;
  localparam int unsigned SEL_CTL = 2;
  localparam int unsigned SEL_PER_CH = 3;
  localparam int unsigned SEL_STATUS = 6;

  // Control register fields
  localparam int unsigned CTL_EN_BIT = 7;
  localparam int unsigned CTL_MD_HI = 4;
  localparam int unsigned CTL_MD_LO = 3;
  localparam int unsigned CTL_DF_HI = 2;
  localparam int unsigned CTL_DF_LO = 0;
  localparam logic [BYTE_W-1:0] CTL_WRITE_MASK = 8'h9f;

  // Status register: channel 1 code position
  localparam int unsigned STAT_CODE1_LO = 16;

  // Reset values
  localparam logic [BYTE_W-1:0] CTL_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] DATA_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_ON_DEMAND = 2'b00,
    MODE_TMR3 = 2'b01,
    MODE_TMR4 = 2'b10,
    MODE_TMR2 = 2'b11
  } update_mode_e;

  // Places the 12-bit code within the high:low pair; 1xx shifts by four
  function automatic logic [CODE_W-1:0] fmt_word(input logic [BYTE_W-1:0] hi,
                                                 input logic [BYTE_W-1:0] lo,
                                                 input logic [2:0] df);
    logic [2*BYTE_W-1:0] pair;
    logic [2:0] sh;
    pair = {hi, lo};
    sh = df[2] ? 3'd4 : {1'b0, df[1:0]};
    fmt_word = CODE_W'(pair >> sh);
  endfunction

endpackage

// [hdl/apb_reg_decode.sv]
// APB address decode into one-hot register selects
module apb_reg_decode
  import dac_sched_pkg::*;
(
  input wire logic [ADDR_W-1:0] paddr,
  output logic [NUM_REGS-1:0] reg_sel,
  output logic hit
);

  always_comb begin
    reg_sel = '0;
    unique case (paddr)
      OFS_CONV0_DATA_HIGH: reg_sel[SEL_HIGH] = 1'b1;
      OFS_CONV0_DATA_LOW: reg_sel[SEL_LOW] = 1'b1;
      OFS_CONV0_CONTROL: reg_sel[SEL_CTL] = 1'b1;
      OFS_CONV1_DATA_HIGH: reg_sel[SEL_PER_CH + SEL_HIGH] = 1'b1;
      OFS_CONV1_DATA_LOW: reg_sel[SEL_PER_CH + SEL_LOW] = 1'b1;
      OFS_CONV1_CONTROL: reg_sel[SEL_PER_CH + SEL_CTL] = 1'b1;
      OFS_CODE_STATUS: reg_sel[SEL_STATUS] = 1'b1;
      default: reg_sel = '0;
    endcase
    hit = |reg_sel;
  end

endmodule

// [hdl/update_select.sv]
// Picks the update event of one channel from its mode field
module update_select
  import dac_sched_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic high_wr,
  input wire logic tmr2_ovf,
  input wire logic tmr3_ovf,
  input wire logic tmr4_ovf,
  output logic update,
  output logic take_new
);

  always_comb begin
    update = 1'b0;
    take_new = 1'b0;
    unique case (update_mode_e'(mode))
      MODE_ON_DEMAND: begin
        update = high_wr; // [RQ3]
        take_new = 1'b1;
      end
      MODE_TMR3: update = tmr3_ovf; // [RQ7]
      MODE_TMR4: update = tmr4_ovf; // [RQ7]
      MODE_TMR2: update = tmr2_ovf; // [RQ7]
    endcase
  end

endmodule

// [hdl/dac_update_scheduler.sv]
// Two-channel DAC update scheduler with APB register access
// Notes on behaviour
// (RQ1) Each channel presents a 12-bit unsigned code, zero for lowest output, all ones for top.
// (RQ2) A channel whose enable bit is clear is shut down with its output inactive.
// (RQ3) In mode 00, the default, a high-byte write moves the staged word into the latch.
// (RQ4) In on-demand mode a low-byte write is only staged and leaves the output alone.
// (RQ5) Software wanting all 12 bits on demand writes the low byte before the high byte.
// (RQ6) For 8-bit use software sets the low byte once and then writes only the high byte.
// (RQ7) Modes 01, 10, 11 stage both bytes and copy them on timer 3, 4 or 2 overflow.
// (RQ8) The update mode is the two-bit field at control bits 4:3.
// (RQ9) The three-bit format field at control bits 2:0 picks one of five word placements.
// (RQ10) The second channel behaves like the first with its own registers.
// (RQ11) Format 000 to 011 takes 4 to 7 top bits from the high byte, 1xx takes eight.
// (RQ12) Enable is control bit 7, bits 6:5 read zero, and the control register resets to zero.
// (RQ13) After reset the staged bytes and the latch hold zero until new data is latched.
module dac_update_scheduler
  import dac_sched_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tmr2_ovf,
  input wire logic tmr3_ovf,
  input wire logic tmr4_ovf,
  output logic [CODE_W-1:0] conv0_code,
  output logic [CODE_W-1:0] conv1_code,
  output logic conv0_active,
  output logic conv1_active
);

  logic [NUM_REGS-1:0] reg_sel;
  logic hit;
  logic wr_access;
  logic [NUM_CH-1:0] hi_wr;
  logic [NUM_CH-1:0] lo_wr;
  logic [NUM_CH-1:0] ctl_wr;
  logic [NUM_CH-1:0] upd;
  logic [NUM_CH-1:0] take_new;

  logic [BYTE_W-1:0] hi_r [NUM_CH];
  logic [BYTE_W-1:0] hi_nxt [NUM_CH];
  logic [BYTE_W-1:0] lo_r [NUM_CH];
  logic [BYTE_W-1:0] lo_nxt [NUM_CH];
  logic [BYTE_W-1:0] ctl_r [NUM_CH];
  logic [BYTE_W-1:0] ctl_nxt [NUM_CH];
  logic [CODE_W-1:0] code_r [NUM_CH];
  logic [CODE_W-1:0] code_nxt [NUM_CH];

  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] prdata_nxt;
  logic ready_r;
  logic ready_nxt;
  logic [DATA_W-1:0] rd_value;

  apb_reg_decode u_decode (
    .paddr(paddr),
    .reg_sel(reg_sel),
    .hit(hit)
  );

  // Read data is loaded in the setup cycle, so the access phase answers at once
  assign pready = penable & ready_r & clk_en;
  assign pslverr = pready & ~hit;
  assign wr_access = psel & penable & pready & pwrite & hit;

  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      hi_wr[ch] = wr_access & reg_sel[ch*SEL_PER_CH + SEL_HIGH];
      lo_wr[ch] = wr_access & reg_sel[ch*SEL_PER_CH + SEL_LOW];
      ctl_wr[ch] = wr_access & reg_sel[ch*SEL_PER_CH + SEL_CTL];
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_sel
    update_select u_update (
      .mode(ctl_r[g][CTL_MD_HI:CTL_MD_LO]),
      .high_wr(hi_wr[g]),
      .tmr2_ovf(tmr2_ovf),
      .tmr3_ovf(tmr3_ovf),
      .tmr4_ovf(tmr4_ovf),
      .update(upd[g]),
      .take_new(take_new[g])
    );
  end

  // Channel state: staging bytes, control and input latch, same for both channels [RQ10]
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      hi_nxt[ch] = hi_r[ch];
      lo_nxt[ch] = lo_r[ch];
      ctl_nxt[ch] = ctl_r[ch];
      code_nxt[ch] = code_r[ch];
      if (hi_wr[ch]) begin
        hi_nxt[ch] = pwdata[BYTE_W-1:0];
      end
      if (lo_wr[ch]) begin
        lo_nxt[ch] = pwdata[BYTE_W-1:0]; // [RQ4]
      end
      if (ctl_wr[ch]) begin
        ctl_nxt[ch] = pwdata[BYTE_W-1:0] & CTL_WRITE_MASK; // [RQ8] [RQ9] [RQ12]
      end
      if (upd[ch]) begin
        // On demand latches the byte being written; timer modes copy the staged pair
        if (take_new[ch]) begin
          code_nxt[ch] = fmt_word(hi_nxt[ch], lo_nxt[ch],
                                  ctl_r[ch][CTL_DF_HI:CTL_DF_LO]); // [RQ3] [RQ11]
        end else begin
          code_nxt[ch] = fmt_word(hi_r[ch], lo_r[ch],
                                  ctl_r[ch][CTL_DF_HI:CTL_DF_LO]); // [RQ7] [RQ11]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        hi_r[ch] <= DATA_RESET; // [RQ13]
        lo_r[ch] <= DATA_RESET; // [RQ13]
        ctl_r[ch] <= CTL_RESET; // [RQ12]
        code_r[ch] <= CODE_RESET; // [RQ13]
      end
    end else if (clk_en) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        hi_r[ch] <= hi_nxt[ch];
        lo_r[ch] <= lo_nxt[ch];
        ctl_r[ch] <= ctl_nxt[ch];
        code_r[ch] <= code_nxt[ch];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_value = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (reg_sel[ch*SEL_PER_CH + SEL_HIGH]) begin
        rd_value[BYTE_W-1:0] = hi_r[ch];
      end
      if (reg_sel[ch*SEL_PER_CH + SEL_LOW]) begin
        rd_value[BYTE_W-1:0] = lo_r[ch];
      end
      if (reg_sel[ch*SEL_PER_CH + SEL_CTL]) begin
        rd_value[BYTE_W-1:0] = ctl_r[ch] & CTL_WRITE_MASK; // [RQ12]
      end
    end
    if (reg_sel[SEL_STATUS]) begin
      rd_value[CODE_W-1:0] = code_r[0];
      rd_value[STAT_CODE1_LO +: CODE_W] = code_r[1];
    end
  end

  always_comb begin
    prdata_nxt = prdata_r;
    ready_nxt = psel & ~(penable & ready_r);
    if (psel && !ready_r) begin
      prdata_nxt = rd_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= RDATA_RESET;
      ready_r <= 1'b0;
    end else if (clk_en) begin
      prdata_r <= prdata_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign prdata = prdata_r;
  assign conv0_code = code_r[0]; // [RQ1]
  assign conv1_code = code_r[1]; // [RQ1]
  // Active flag follows the enable bit; the code outputs are driven from the latch regardless
  assign conv0_active = ctl_r[0][CTL_EN_BIT]; // [RQ2]
  assign conv1_active = ctl_r[1][CTL_EN_BIT]; // [RQ2]

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ondemand_latch: assert property ( // [RQ3]
    (hi_wr[0] && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND)
      |=> conv0_code == fmt_word(hi_r[0], lo_r[0], ctl_r[0][CTL_DF_HI:CTL_DF_LO])
  ) else $error("Channel 0 high write in on-demand mode did not latch");

  chk_low_staged_only: assert property ( // [RQ4]
    (lo_wr[0] && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND) |=> $stable(conv0_code)
  ) else $error("Channel 0 low write changed the output");

  chk_timer3_copy: assert property ( // [RQ7]
    (clk_en && tmr3_ovf && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_TMR3)
      |=> conv0_code == fmt_word($past(hi_r[0]), $past(lo_r[0]),
                                 $past(ctl_r[0][CTL_DF_HI:CTL_DF_LO]))
  ) else $error("Channel 0 did not copy staged pair on timer 3 overflow");

  chk_timer_hold: assert property ( // [RQ7]
    (ctl_r[0][CTL_MD_HI:CTL_MD_LO] != MODE_ON_DEMAND && !(tmr2_ovf || tmr3_ovf || tmr4_ovf))
      |=> $stable(conv0_code)
  ) else $error("Channel 0 output changed without a timer overflow");

  chk_mode_field: assert property ( // [RQ8]
    ctl_wr[1] |=> ctl_r[1][CTL_MD_HI:CTL_MD_LO] == $past(pwdata[CTL_MD_HI:CTL_MD_LO])
  ) else $error("Mode field not stored from bits 4:3");

  chk_enable_path: assert property ( // [RQ2]
    (ctl_wr[0] && pwdata[CTL_EN_BIT]) |=> conv0_active ##0 ctl_r[0][6:5] == 2'b00
  ) else $error("Enable write did not activate channel 0");

  chk_unused_bits: assert property ( // [RQ12]
    ctl_r[0][6:5] == 2'b00 && ctl_r[1][6:5] == 2'b00
  ) else $error("Unused control bits set");

  chk_ch1_ondemand: assert property ( // [RQ10]
    (hi_wr[1] && ctl_r[1][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND)
      |=> conv1_code == fmt_word(hi_r[1], lo_r[1], ctl_r[1][CTL_DF_HI:CTL_DF_LO])
  ) else $error("Channel 1 high write in on-demand mode did not latch");

  chk_no_event_hold: assert property ( // [RQ13]
    (!upd[1] || !clk_en) |=> $stable(conv1_code)
  ) else $error("Channel 1 latch changed without an update event");

  chk_ch0_event_hold: assert property ( // [RQ13]
    (!upd[0] || !clk_en) |=> $stable(conv0_code)
  ) else $error("Channel 0 latch changed without an update event");

  chk_freeze_state: assert property ( // [RQ13]
    !clk_en |=> $stable(hi_r[0]) && $stable(lo_r[0]) && $stable(ctl_r[0])
      && $stable(conv0_code) && $stable(conv1_code)
  ) else $error("State moved while the clock enable was low");

  chk_ch1_low_staged: assert property ( // [RQ4]
    (lo_wr[1] && ctl_r[1][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND) |=> $stable(conv1_code)
  ) else $error("Channel 1 low write changed the output");

  chk_timer4_copy: assert property ( // [RQ7]
    (clk_en && tmr4_ovf && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_TMR4)
      |=> conv0_code == fmt_word($past(hi_r[0]), $past(lo_r[0]),
                                 $past(ctl_r[0][CTL_DF_HI:CTL_DF_LO]))
  ) else $error("Channel 0 did not copy staged pair on timer 4 overflow");

  chk_timer2_copy: assert property ( // [RQ7]
    (clk_en && tmr2_ovf && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_TMR2)
      |=> conv0_code == fmt_word($past(hi_r[0]), $past(lo_r[0]),
                                 $past(ctl_r[0][CTL_DF_HI:CTL_DF_LO]))
  ) else $error("Channel 0 did not copy staged pair on timer 2 overflow");

  chk_ch1_timer2_copy: assert property ( // [RQ10]
    (clk_en && tmr2_ovf && ctl_r[1][CTL_MD_HI:CTL_MD_LO] == MODE_TMR2)
      |=> conv1_code == fmt_word($past(hi_r[1]), $past(lo_r[1]),
                                 $past(ctl_r[1][CTL_DF_HI:CTL_DF_LO]))
  ) else $error("Channel 1 did not copy staged pair on timer 2 overflow");

  chk_ch1_timer_hold: assert property ( // [RQ7]
    (ctl_r[1][CTL_MD_HI:CTL_MD_LO] != MODE_ON_DEMAND && !(tmr2_ovf || tmr3_ovf || tmr4_ovf))
      |=> $stable(conv1_code)
  ) else $error("Channel 1 output changed without a timer overflow");

  chk_staged_high: assert property ( // [RQ7]
    (hi_wr[0] && ctl_r[0][CTL_MD_HI:CTL_MD_LO] != MODE_ON_DEMAND)
      |=> hi_r[0] == $past(pwdata[BYTE_W-1:0])
  ) else $error("Channel 0 high byte not staged in timer mode");

  chk_ch0_mode_field: assert property ( // [RQ8]
    ctl_wr[0] |=> ctl_r[0][CTL_MD_HI:CTL_MD_LO] == $past(pwdata[CTL_MD_HI:CTL_MD_LO])
  ) else $error("Channel 0 mode field not stored from bits 4:3");

  chk_format_field: assert property ( // [RQ9]
    ctl_wr[0] |=> ctl_r[0][CTL_DF_HI:CTL_DF_LO] == $past(pwdata[CTL_DF_HI:CTL_DF_LO])
  ) else $error("Channel 0 format field not stored from bits 2:0");

  chk_ch1_format_field: assert property ( // [RQ9]
    ctl_wr[1] |=> ctl_r[1][CTL_DF_HI:CTL_DF_LO] == $past(pwdata[CTL_DF_HI:CTL_DF_LO])
  ) else $error("Channel 1 format field not stored from bits 2:0");

  chk_place_nibble: assert property ( // [RQ11]
    (hi_wr[0] && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND
      && ctl_r[0][CTL_DF_HI:CTL_DF_LO] == 3'b000) |=> conv0_code == {hi_r[0][3:0], lo_r[0]}
  ) else $error("Format 000 did not place the nibble and low byte");

  chk_place_five: assert property ( // [RQ11]
    (hi_wr[0] && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND
      && ctl_r[0][CTL_DF_HI:CTL_DF_LO] == 3'b001) |=> conv0_code == {hi_r[0][4:0], lo_r[0][7:1]}
  ) else $error("Format 001 did not place five high bits");

  chk_place_byte: assert property ( // [RQ11]
    (hi_wr[0] && ctl_r[0][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND && ctl_r[0][CTL_DF_HI])
      |=> conv0_code == {hi_r[0], lo_r[0][7:4]}
  ) else $error("Format 1xx did not place the whole high byte");

  chk_ch1_place_byte: assert property ( // [RQ10]
    (hi_wr[1] && ctl_r[1][CTL_MD_HI:CTL_MD_LO] == MODE_ON_DEMAND && ctl_r[1][CTL_DF_HI])
      |=> conv1_code == {hi_r[1], lo_r[1][7:4]}
  ) else $error("Channel 1 format 1xx did not place the whole high byte");

  chk_enable_bit: assert property ( // [RQ12]
    ctl_wr[0] |=> conv0_active == $past(pwdata[CTL_EN_BIT])
  ) else $error("Channel 0 enable does not follow control bit 7");

  chk_ch1_enable_bit: assert property ( // [RQ10]
    ctl_wr[1] |=> conv1_active == $past(pwdata[CTL_EN_BIT])
  ) else $error("Channel 1 enable does not follow control bit 7");

endmodule

// [bench/core_model.sv]
// Processor core model: issues APB transfers to the scheduler
module core_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Holds the request until pready is seen at an edge; ok low means no answer came
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) ok = 1'b1;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the two-channel DAC update scheduler
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  $display("wrong value %s expected %h seen %h", nm, ex, got); num_errors++; end end
module tb
  import dac_sched_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] tmr;
  logic [11:0] conv0_code, conv1_code;
  logic conv0_active, conv1_active;
  int num_errors = 0;
  int comparisons = 0;
  core_model core_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dac_update_scheduler dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr2_ovf(tmr[0]), .tmr3_ovf(tmr[1]),
    .tmr4_ovf(tmr[2]), .conv0_code(conv0_code), .conv1_code(conv1_code),
    .conv0_active(conv0_active), .conv1_active(conv1_active));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    bit ok;
    core_u.xfer(w, a, {24'h000000, d}, r, e, ok);
    if (!ok) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    acc(1'b1, a, d, r, e);
    #1;
  endtask
  function automatic logic [11:0] code(input int ch);
    return ch ? conv1_code : conv0_code;
  endfunction
  function automatic logic act(input int ch);
    return ch ? conv1_active : conv0_active;
  endfunction
  task automatic pulse(input logic [2:0] m);
    @(posedge pclk);
    tmr <= m;
    @(posedge pclk);
    tmr <= 3'b000;
    #1;
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 3; k++) begin
        acc(1'b0, 8'(ch * 16 + k * 4), 8'h00, r, e);
        `CHK("reset reg", 32'h0000_0000, r)
      end
      `CHK("reset code", 12'h000, code(ch))
      `CHK("reset active", 1'b0, act(ch))
    end
    acc(1'b0, OFS_CODE_STATUS, 8'h00, r, e);
    `CHK("reset status", 32'h0000_0000, r)
    $display("test reset done");
  endtask
  task automatic t_ctl(input int ch);
    logic [31:0] r;
    logic e;
    wr(8'(ch * 16 + 8), 8'hff);
    acc(1'b0, 8'(ch * 16 + 8), 8'h00, r, e);
    `CHK("control read", 32'h0000_009f, r)
    `CHK("active on", 1'b1, act(ch))
    wr(8'(ch * 16 + 8), 8'h00);
    `CHK("active off", 1'b0, act(ch))
    $display("test control %0d done", ch);
  endtask
  task automatic t_fmt(input int ch);
    logic [15:0] pair;
    logic [11:0] prev;
    for (int df = 0; df < 8; df++) begin
      pair = {8'(8'h90 + df * 9), 8'(8'h3c + df * 17)};
      prev = code(ch);
      wr(8'(ch * 16 + 8), 8'(df));
      wr(8'(ch * 16 + 4), pair[7:0]); // Low byte first
      `CHK("low staged", prev, code(ch))
      wr(8'(ch * 16), pair[15:8]);
      `CHK("placed code", 12'(pair >> (df >= 4 ? 4 : df)), code(ch))
    end
    wr(8'(ch * 16), 8'hff); // Only high byte written for 8-bit use
    `CHK("full scale", 12'hff0 | 12'(pair[7:4]), code(ch))
    $display("test format %0d done", ch);
  endtask
  task automatic t_timer(input int ch);
    logic [15:0] pair;
    logic [11:0] prev;
    logic [2:0] hit;
    logic [31:0] r;
    logic e;
    for (int m = 1; m < 4; m++) begin
      hit = (m == 1) ? 3'b010 : (m == 2) ? 3'b100 : 3'b001;
      pair = {8'(8'h51 * m), 8'(8'he7 - m * 32)};
      prev = code(ch);
      wr(8'(ch * 16 + 8), {3'b000, 2'(m), 3'b100});
      wr(8'(ch * 16 + 4), pair[7:0]);
      wr(8'(ch * 16), pair[15:8]);
      `CHK("held on write", prev, code(ch))
      pulse(~hit);
      `CHK("other timer", prev, code(ch))
      pulse(hit);
      `CHK("timer update", 12'(pair >> 4), code(ch))
      acc(1'b0, OFS_CODE_STATUS, 8'h00, r, e);
      `CHK("status code", 12'(pair >> 4), r[ch * STAT_CODE1_LO +: 12])
    end
    wr(8'(ch * 16 + 8), 8'h00);
    $display("test timer %0d done", ch);
  endtask
  task automatic t_bad();
    logic [31:0] r;
    logic e;
    acc(1'b1, 8'h0c, 8'h5a, r, e);
    `CHK("write error", 1'b1, e)
    acc(1'b0, 8'h0c, 8'h00, r, e);
    `CHK("read error", 1'b1, e)
    `CHK("read data", 32'h0000_0000, r)
    $display("test unmapped done");
  endtask
  task automatic t_freeze();
    logic [11:0] prev;
    wr(OFS_CONV0_CONTROL, 8'h0c); // Timer 3 mode, format 1xx
    wr(OFS_CONV0_DATA_LOW, 8'ha5);
    wr(OFS_CONV0_DATA_HIGH, 8'h3c);
    prev = code(0);
    @(posedge pclk);
    clk_en <= 1'b0;
    tmr <= 3'b010;
    @(posedge pclk);
    tmr <= 3'b000;
    @(posedge pclk);
    clk_en <= 1'b1;
    #1;
    `CHK("frozen code", prev, code(0))
    pulse(3'b010);
    `CHK("thawed code", 12'h3ca, code(0))
    wr(OFS_CONV0_CONTROL, 8'h00);
    $display("test clock enable done");
  endtask
  task automatic t_midreset();
    wr(OFS_CONV0_DATA_LOW, 8'h77);
    wr(OFS_CONV0_DATA_HIGH, 8'h12);
    wr(OFS_CONV1_CONTROL, 8'h80);
    `CHK("before reset", 12'h277, code(0))
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
  endtask
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    tmr = 3'b000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (int ch = 0; ch < 2; ch++) begin
      t_ctl(ch);
      t_fmt(ch);
      t_timer(ch);
    end
    t_bad();
    t_freeze();
    t_midreset();
    report_and_stop();
  end
endmodule
